// ===== logic/slave_port_map.svh
// register map, field positions, reset values and pin constants of the slave port
`ifndef SLAVE_PORT_MAP_SVH
`define SLAVE_PORT_MAP_SVH

// ====================================================================
// register byte offsets on the wishbone bus
`define SP_ADR_CTRL      8'h00
`define SP_ADR_DATA      8'h04
`define SP_ADR_GPIO_DIR  8'h08
`define SP_ADR_PIN_DIR   8'h0C
`define SP_ADR_EVT_STAT  8'h10
`define SP_ADR_EVT_MASK  8'h14

// ====================================================================
// slave_port_control fields
`define SP_CTRL_INFULL   7
`define SP_CTRL_OUTFULL  6
`define SP_CTRL_OVF      5
`define SP_CTRL_MODE     4

// ====================================================================
// event status / mask fields
`define SP_EVT_N         2
`define SP_EVT_PORT      0
`define SP_EVT_OVF       1

// ====================================================================
// widths and reset values
`define SP_PORT_W        8
`define SP_WB_W          32
`define SP_PIN_DIR_W     3
`define SP_PIN_DIR_IN    3'h7
`define SP_PIN_DIR_RST   3'h7
`define SP_GPIO_DIR_RST  8'hFF
`define SP_BYTE_ZERO     8'h00
`define SP_BYTE_ONES     8'hFF
`define SP_WORD_ZERO     32'h0000_0000
`define SP_EVT_ZERO      2'h0

`endif

// ===== logic/slave_port_pkg.sv
// state types of the parallel slave port and its helpers
`default_nettype none
`include "slave_port_map.svh"

package slave_port_pkg;

	// ================================================================
	// state of one strobe-pair access detector
	typedef struct packed {
		logic active;
		logic start;
		logic stop;
	} access_state_t;

	// ================================================================
	// state of the sticky event / mask / interrupt block
	typedef struct packed {
		logic [`SP_EVT_N-1:0] status;
		logic [`SP_EVT_N-1:0] mask;
		logic                 irq;
	} event_state_t;

	// ================================================================
	// state of the main port block
	typedef struct packed {
		logic                     mode;
		logic                     in_full;
		logic                     out_full;
		logic                     overflow;
		logic [`SP_PIN_DIR_W-1:0] pin_dir;
		logic [`SP_PORT_W-1:0]    in_word;
		logic [`SP_PORT_W-1:0]    shadow;
		logic [`SP_PORT_W-1:0]    out_word;
		logic [`SP_PORT_W-1:0]    gpio_dir;
		logic                     ack;
		logic [`SP_WB_W-1:0]      rdata;
		logic [`SP_PORT_W-1:0]    data_out;
		logic [`SP_PORT_W-1:0]    data_oe;
	} port_state_t;

endpackage : slave_port_pkg

`default_nettype wire

// ===== logic/access_detect.sv
// start / stop pulse detector for one chip-select and strobe pair
`default_nettype none
`include "slave_port_map.svh"

module access_detect (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_enable,
	input  wire logic i_chip_select_n,
	input  wire logic i_strobe_n,
	output logic      o_active,
	output logic      o_start,
	output logic      o_stop
);

	slave_port_pkg::access_state_t s;
	slave_port_pkg::access_state_t next_s;
	logic                          seen;

	// ================================================================
	// access is live while both lines are low; either going high ends it
	always_comb begin
		seen = i_enable & ~i_chip_select_n & ~i_strobe_n;
		next_s = s;
		next_s.active = seen;
		next_s.start = seen & ~s.active;
		next_s.stop = ~seen & s.active; // mode drop also closes access
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_active = s.active;
	assign o_start = s.start;
	assign o_stop = s.stop;

endmodule // access_detect

`default_nettype wire

// ===== logic/port_events.sv
// sticky event flags with write-one-to-clear, mask and level interrupt
`default_nettype none
`include "slave_port_map.svh"

module port_events (
	input  wire logic                 i_clk,
	input  wire logic                 i_sys_rst,
	input  wire logic [`SP_EVT_N-1:0] i_set,
	input  wire logic                 i_clr_we,
	input  wire logic [`SP_EVT_N-1:0] i_clr,
	input  wire logic                 i_mask_we,
	input  wire logic [`SP_EVT_N-1:0] i_mask,
	output logic      [`SP_EVT_N-1:0] o_status,
	output logic      [`SP_EVT_N-1:0] o_mask,
	output logic                      o_irq
);

	slave_port_pkg::event_state_t s;
	slave_port_pkg::event_state_t next_s;

	// ================================================================
	// clear first, set after: an event in the clear cycle is kept
	always_comb begin
		next_s = s;
		if (i_clr_we) begin
			next_s.status = s.status & ~i_clr;
		end
		next_s.status = next_s.status | i_set;
		if (i_mask_we) begin
			next_s.mask = i_mask;
		end
		next_s.irq = |(next_s.status & next_s.mask);
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_status = s.status;
	assign o_mask = s.mask;
	assign o_irq = s.irq;

endmodule // port_events

`default_nettype wire

// ===== logic/host_slave_port.sv
// parallel slave port: external 8-bit host access to a data latch
// What this block does
// - the data port acts as slave port only while the mode select bit 4 is set.
// - in slave port mode the read strobe, write strobe and chip select are inputs.
// - with mode select cleared the data port is general purpose i/o.
// - the host reaches one 8-bit latch with strobes sampled by the device.
// - a write runs while select and write strobe are low and ends when one rises.
// - the end of a host write sets the port event flag and the input full flag.
// - the input full flag shows a received word not yet read by the cpu.
// - a host write onto an unread word sets the overflow flag until cleared.
// - a read starts when select and read strobe are low and drives the latch.
// - the output full flag shows a cpu word not yet read by the host.
// - a cpu write during a host read is driven at once and leaves output full clear.
// - when select or read strobe rises the pins return to input and the event sets.
// - control holds only its upper four bits; full flags read-only, all reset zero.
`default_nettype none
`include "slave_port_map.svh"

module host_slave_port #(
	parameter int ADR_W = 8
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_sys_rst,
	// wishbone classic slave
	input  wire logic                  i_wb_cyc,
	input  wire logic                  i_wb_stb,
	input  wire logic                  i_wb_we,
	input  wire logic [ADR_W-1:0]      i_wb_adr,
	input  wire logic [3:0]            i_wb_sel,
	input  wire logic [`SP_WB_W-1:0]   i_wb_dat,
	output logic                       o_wb_ack,
	output logic      [`SP_WB_W-1:0]   o_wb_dat,
	// host side pins
	input  wire logic                  i_read_strobe_n,
	input  wire logic                  i_write_strobe_n,
	input  wire logic                  i_chip_select_n,
	input  wire logic [`SP_PORT_W-1:0] i_data_pin,
	output logic      [`SP_PORT_W-1:0] o_data_out,
	output logic      [`SP_PORT_W-1:0] o_data_oe,
	// interrupt
	output logic                       o_irq
);

	// ================================================================
	// elaboration check
	if (ADR_W < 8) begin : g_adr_check
		$error("host_slave_port: ADR_W must be at least 8");
	end

	slave_port_pkg::port_state_t s;
	slave_port_pkg::port_state_t next_s;

	logic                 port_on;
	logic                 wr_seen;
	logic                 rd_seen;
	logic                 wr_active;
	logic                 wr_start;
	logic                 wr_stop;
	logic                 rd_active;
	logic                 rd_start;
	logic                 rd_stop;
	logic                 bus_go;
	logic                 bus_wr;
	logic                 bus_rd;
	logic                 cpu_data_rd;
	logic                 cpu_data_wr;
	logic [`SP_EVT_N-1:0] evt_set;
	logic [`SP_EVT_N-1:0] evt_status;
	logic [`SP_EVT_N-1:0] evt_mask;
	logic                 evt_irq;

	// ================================================================
	// address decode, used for every register
	function automatic logic hit(input logic [ADR_W-1:0] adr,
			input logic [7:0] off);
		// upper address bits must be zero; a shift stays legal at ADR_W == 8
		hit = (adr[7:2] == off[7:2]) && ((adr >> 8) == '0);
	endfunction

	// ================================================================
	// control pins count as strobes only in mode with all three inputs
	assign port_on = s.mode & (s.pin_dir == `SP_PIN_DIR_IN);
	assign wr_seen = port_on & ~i_chip_select_n & ~i_write_strobe_n;
	assign rd_seen = port_on & ~i_chip_select_n & ~i_read_strobe_n;

	access_detect u_write_detect (
		.i_clk           (i_clk),
		.i_sys_rst       (i_sys_rst),
		.i_enable        (port_on),
		.i_chip_select_n (i_chip_select_n),
		.i_strobe_n      (i_write_strobe_n),
		.o_active        (wr_active),
		.o_start         (wr_start),
		.o_stop          (wr_stop)
	);

	access_detect u_read_detect (
		.i_clk           (i_clk),
		.i_sys_rst       (i_sys_rst),
		.i_enable        (port_on),
		.i_chip_select_n (i_chip_select_n),
		.i_strobe_n      (i_read_strobe_n),
		.o_active        (rd_active),
		.o_start         (rd_start),
		.o_stop          (rd_stop)
	);

	// ================================================================
	// bus strobes: one request is served once, ack in the next cycle
	assign bus_go = i_wb_cyc & i_wb_stb & ~s.ack;
	assign bus_wr = bus_go & i_wb_we & i_wb_sel[0];
	assign bus_rd = bus_go & ~i_wb_we;
	assign cpu_data_rd = bus_rd & hit(i_wb_adr, `SP_ADR_DATA);
	assign cpu_data_wr = bus_wr & hit(i_wb_adr, `SP_ADR_DATA);

	// ================================================================
	// events: any host access end, and an overflow
	always_comb begin
		evt_set = `SP_EVT_ZERO;
		evt_set[`SP_EVT_PORT] = wr_stop | rd_stop;
		evt_set[`SP_EVT_OVF] = wr_stop & s.in_full & ~cpu_data_rd;
	end

	port_events u_events (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_set     (evt_set),
		.i_clr_we  (bus_wr & hit(i_wb_adr, `SP_ADR_EVT_STAT)),
		.i_clr     (i_wb_dat[`SP_EVT_N-1:0]),
		.i_mask_we (bus_wr & hit(i_wb_adr, `SP_ADR_EVT_MASK)),
		.i_mask    (i_wb_dat[`SP_EVT_N-1:0]),
		.o_status  (evt_status),
		.o_mask    (evt_mask),
		.o_irq     (evt_irq)
	);

	// ================================================================
	// next state: software clears first, hardware sets win afterwards
	always_comb begin
		next_s = s;
		next_s.ack = bus_go;
		next_s.rdata = `SP_WORD_ZERO;

		// register reads; unmapped offsets answer zero
		if (bus_rd) begin
			if (hit(i_wb_adr, `SP_ADR_CTRL)) begin
				next_s.rdata[`SP_CTRL_INFULL] = s.in_full;
				next_s.rdata[`SP_CTRL_OUTFULL] = s.out_full;
				next_s.rdata[`SP_CTRL_OVF] = s.overflow;
				next_s.rdata[`SP_CTRL_MODE] = s.mode;
			end else if (hit(i_wb_adr, `SP_ADR_DATA)) begin
				// slave mode shows the received word, else the pins
				next_s.rdata[`SP_PORT_W-1:0] =
					s.mode ? s.in_word : i_data_pin;
			end else if (hit(i_wb_adr, `SP_ADR_GPIO_DIR)) begin
				next_s.rdata[`SP_PORT_W-1:0] = s.gpio_dir;
			end else if (hit(i_wb_adr, `SP_ADR_PIN_DIR)) begin
				next_s.rdata[`SP_PIN_DIR_W-1:0] = s.pin_dir;
			end else if (hit(i_wb_adr, `SP_ADR_EVT_STAT)) begin
				next_s.rdata[`SP_EVT_N-1:0] = evt_status;
			end else if (hit(i_wb_adr, `SP_ADR_EVT_MASK)) begin
				next_s.rdata[`SP_EVT_N-1:0] = evt_mask;
			end
		end

		// cpu read of the latch takes the waiting word
		if (s.mode && cpu_data_rd) begin
			next_s.in_full = 1'b0;
		end

		// register writes; full flags are not writable
		if (bus_wr && hit(i_wb_adr, `SP_ADR_CTRL)) begin
			next_s.overflow = i_wb_dat[`SP_CTRL_OVF];
			next_s.mode = i_wb_dat[`SP_CTRL_MODE];
		end
		if (bus_wr && hit(i_wb_adr, `SP_ADR_GPIO_DIR)) begin
			next_s.gpio_dir = i_wb_dat[`SP_PORT_W-1:0];
		end
		if (bus_wr && hit(i_wb_adr, `SP_ADR_PIN_DIR)) begin
			next_s.pin_dir = i_wb_dat[`SP_PIN_DIR_W-1:0];
		end

		// cpu write of the latch; during a host read no full flag
		if (cpu_data_wr) begin
			next_s.out_word = i_wb_dat[`SP_PORT_W-1:0];
			if (s.mode && !rd_active) begin
				next_s.out_full = 1'b1;
			end
		end

		// host write: follow the pins while the strobes are low
		if (wr_seen) begin
			next_s.shadow = i_data_pin;
		end
		if (wr_stop) begin
			next_s.in_word = s.shadow;
			next_s.in_full = 1'b1;
			if (s.in_full && !cpu_data_rd) begin
				next_s.overflow = 1'b1;
			end
		end

		// host read: the word counts as taken at its start
		if (rd_start) begin
			next_s.out_full = 1'b0;
		end

		// pins: host read drives the latch, gpio follows its direction
		next_s.data_out = next_s.out_word;
		if (port_on) begin
			next_s.data_oe = rd_seen ? `SP_BYTE_ONES
				: `SP_BYTE_ZERO;
		end else begin
			next_s.data_oe = ~next_s.gpio_dir;
		end
	end

	// ================================================================
	// state register
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s <= '0;
			s.pin_dir <= `SP_PIN_DIR_RST;
			s.gpio_dir <= `SP_GPIO_DIR_RST;
		end else begin
			s <= next_s;
		end
	end

	// ================================================================
	// outputs straight from flip-flops
	assign o_wb_ack = s.ack;
	assign o_wb_dat = s.rdata;
	assign o_data_out = s.data_out;
	assign o_data_oe = s.data_oe;
	assign o_irq = evt_irq;

endmodule // host_slave_port

`default_nettype wire

// ===== bench/host_slave_port_properties.sv
// assertions on the slave port's bus, pin and interrupt outputs
`default_nettype none

module host_slave_port_properties (
	input wire logic        i_clk,
	input wire logic        i_sys_rst,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic        o_wb_ack,
	input wire logic [31:0] o_wb_dat,
	input wire logic        i_read_strobe_n,
	input wire logic        i_chip_select_n,
	input wire logic [7:0]  o_data_out,
	input wire logic [7:0]  o_data_oe,
	input wire logic        o_irq
);
	// a write request taken at this edge
	logic take;
	assign take = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	// ====================================================================
	// bus answers
	a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack held past one cycle");
	a_ack_latency: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
		|=> o_wb_ack) else $error("request not answered next cycle");
	a_ack_cause: assert property ($rose(o_wb_ack)
		|-> $past(i_wb_cyc && i_wb_stb)) else $error("ack without request");
	a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
		else $error("read data outside ack");
	a_dat_upper: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
		else $error("unused read bits not zero");

	// ====================================================================
	// pins and interrupt; the bench keeps gpio direction off 00 so that
	// an all-ones enable can only come from a host read
	a_out_cause: assert property ($changed(o_data_out)
		|-> $past(take) || $past(take, 2)) else $error("latch moved alone");
	a_oe_release: assert property (o_data_oe == 8'hFF &&
		(i_chip_select_n || i_read_strobe_n) |=> o_data_oe == 8'h00)
		else $error("pins not released after read");
	a_irq_fall: assert property ($fell(o_irq)
		|-> $past(take) || $past(take, 2)) else $error("irq fell alone");
endmodule // host_slave_port_properties

bind host_slave_port host_slave_port_properties u_props (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .o_wb_ack(o_wb_ack),
	.o_wb_dat(o_wb_dat), .i_read_strobe_n(i_read_strobe_n),
	.i_chip_select_n(i_chip_select_n), .o_data_out(o_data_out),
	.o_data_oe(o_data_oe), .o_irq(o_irq));

`default_nettype wire

// ===== bench/ext_host_model.sv
// external 8-bit microprocessor that writes and reads the slave port
`default_nettype none

module ext_host_model (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_data_out,
	input  wire logic [7:0] i_data_oe,
	output logic            o_cs_n,
	output logic            o_rd_n,
	output logic            o_wr_n,
	output logic [7:0]      o_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] drv = 8'h00;

	// ====================================================================
	// each pin shows the device where it drives and our value elsewhere
	assign o_pin = (i_data_oe & i_data_out) | (~i_data_oe & drv);
	initial begin
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
	end
	// one whole byte per strobe pair, data held over the low window
	task automatic put(input logic [7:0] b, input int lo);
		drv <= b;
		o_cs_n <= 1'b0;
		o_wr_n <= 1'b0;
		repeat (lo) @(posedge i_clk);
		o_wr_n <= 1'b1;
		o_cs_n <= 1'b1;
		drv <= ~b; // released bus must not keep showing the byte
		repeat (3) @(posedge i_clk);
	endtask
	// the byte is taken in the last cycle of the low window
	task automatic get(output logic [7:0] b, input int lo);
		o_cs_n <= 1'b0;
		o_rd_n <= 1'b0;
		repeat (lo) @(posedge i_clk);
		b = o_pin;
		o_rd_n <= 1'b1;
		o_cs_n <= 1'b1;
		repeat (3) @(posedge i_clk);
	endtask
endmodule // ext_host_model

`default_nettype wire

// ===== bench/tb.sv
// testbench: registers, host traffic and interrupt against a small model
`default_nettype none
`include "slave_port_map.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        i_wb_cyc = 1'b0;
	logic        i_wb_stb = 1'b0;
	logic        i_wb_we = 1'b0;
	logic [7:0]  i_wb_adr = 8'h00;
	logic [3:0]  i_wb_sel = 4'h0;
	logic [31:0] i_wb_dat = 32'h0000_0000;
	logic        o_wb_ack, o_irq, rd_n, wr_n, cs_n;
	logic [31:0] o_wb_dat;
	logic [7:0]  pin, dout, doe;
	int          bad_count = 0;
	int          checked = 0;
	bit          mode, inf, outf, ovf;
	int          stat, mask, lat, rx;

	always #2.5 i_clk = ~i_clk;
	host_slave_port #(.ADR_W(8)) dut (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc),
		.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
		.i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack),
		.o_wb_dat(o_wb_dat), .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n),
		.i_chip_select_n(cs_n), .i_data_pin(pin), .o_data_out(dout),
		.o_data_oe(doe), .o_irq(o_irq));
	ext_host_model host (.i_clk(i_clk), .i_data_out(dout), .i_data_oe(doe),
		.o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_pin(pin));

	// ====================================================================
	// comparison, bus cycle and verdict
	task automatic chk(input string s, input logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("unexpected %s: expected %h seen %h", s, e, g);
			bad_count++;
		end
	endtask
	task automatic bus(input logic w, logic [7:0] a, logic [31:0] d,
		logic [3:0] s, output logic [31:0] q);
		int n;
		n = 0;
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= w;
		i_wb_adr <= a;
		i_wb_dat <= d;
		i_wb_sel <= s;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 50);
		if (n == 50) bad_count++;
		q = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hF, q);
	endtask
	task automatic rchk(input string s, input logic [7:0] a, input int e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, 4'hF, q);
		chk(s, 32'(e), q);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// ====================================================================
	// model-driven operations
	task automatic cmp_all();
		rchk("control", `SP_ADR_CTRL, int'({inf, outf, ovf, mode, 4'h0}));
		rchk("status", `SP_ADR_EVT_STAT, stat);
		chk("irq", 32'((stat & mask) != 0), 32'(o_irq));
	endtask
	task automatic hwr(input logic [7:0] b); // strobe length prompt or slow
		host.put(b, 2 + $urandom % 3);
		if (mode) begin
			ovf |= inf;
			stat |= inf ? 3 : 1;
			inf = 1'b1;
			rx = b;
		end
	endtask
	task automatic hrd();
		logic [7:0] b;
		// pins drive one cycle after the strobes are seen, so hold them 3+
		host.get(b, 3 + $urandom % 3);
		if (mode) begin
			chk("host byte", lat, b);
			outf = 1'b0;
			stat |= 1;
		end
	endtask
	task automatic cwr(input int v);
		wr(`SP_ADR_DATA, v);
		lat = v & 255;
		outf |= mode;
	endtask
	task automatic crd(); // word left after an overflow is not compared
		logic [31:0] q;
		bus(1'b0, `SP_ADR_DATA, 32'h0000_0000, 4'hF, q);
		if (mode && !ovf) chk("cpu byte", rx, q);
		inf &= !mode;
	endtask

	initial begin
		logic [7:0]  b;
		logic [31:0] q;
		int          v;
		void'($urandom(44126));
		repeat (3) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_clk);
		rchk("pin dir", `SP_ADR_PIN_DIR, 7);
		rchk("gpio dir", `SP_ADR_GPIO_DIR, 255);
		rchk("mask", `SP_ADR_EVT_MASK, 0);
		rchk("unmapped", 8'h18, 0);
		bus(1'b1, `SP_ADR_CTRL, 32'hFF, 4'hE, q);
		cmp_all();
		wr(`SP_ADR_CTRL, 32'hFF);
		{ovf, mode} = 2'h3;
		cmp_all();
		wr(`SP_ADR_CTRL, 32'h00);
		{ovf, mode} = 2'h0;
		// gpio mode: strobes ignored, pins follow the direction register
		wr(`SP_ADR_GPIO_DIR, 32'h0F);
		cwr($urandom);
		chk("gpio oe", 8'hF0, doe);
		chk("gpio out", lat, dout);
		hwr($urandom);
		hrd();
		cmp_all();
		wr(`SP_ADR_GPIO_DIR, 32'hFF);
		wr(`SP_ADR_PIN_DIR, 32'h7);
		wr(`SP_ADR_CTRL, 32'h10);
		mode = 1'b1;
		wr(`SP_ADR_EVT_MASK, 32'h1);
		mask = 1;
		for (int i = 0; i < 4; i++) begin
			cwr($urandom);
			cmp_all();
			hrd();
			cmp_all();
			hwr($urandom);
			cmp_all();
			crd();
			cmp_all();
			wr(`SP_ADR_EVT_STAT, 32'h3);
			stat = 0;
		end
		// second host write onto an unread word, then masking
		hwr($urandom);
		hwr($urandom);
		cmp_all();
		wr(`SP_ADR_EVT_MASK, 32'h0);
		mask = 0;
		crd();
		cmp_all();
		wr(`SP_ADR_CTRL, 32'h10);
		wr(`SP_ADR_EVT_STAT, 32'h3);
		{ovf, stat} = 0;
		cmp_all();
		// cpu write while the host reads: new byte shows at once
		v = $urandom % 256;
		fork
			host.get(b, 6);
			begin
				repeat (2) @(posedge i_clk);
				wr(`SP_ADR_DATA, v);
			end
		join
		chk("live byte", v, b);
		{lat, stat} = {v, 1};
		cmp_all();
		summarize();
	end

	// hang guard: the sequence needs a few hundred cycles
	initial begin
		#100us;
		bad_count++;
		summarize();
	end
endmodule // tb

`default_nettype wire
